// >>> logic/taic_pkg.sv
// constants for the trap and interrupt control block
// assumes a classic wishbone slave, 32-bit data, 16-bit registers in the low half
// Function
// - upper priority bit reads 1 exactly when priority level is above 7
// - priority level is upper bit over the three-bit status field
// - accumulator a and b overflow traps set their own flags
// - catastrophic overflow of a sets bit 12, of b bit 11
// - overflow traps for a and b need enables at bits 10 and 9
// - catastrophic overflow traps need the enable at bit 8
// - invalid accumulator shift math trap sets bit 7
// - divide by zero math trap sets bit 6
// - dma controller error trap sets bit 5
// - any math error trap sets bit 4
// - address, stack and oscillator traps set bits 3, 2 and 1
// - alternate table select at bit 15 picks the vector table
// - read-only bit 14 shows temporary interrupt disable in effect
// - polarity bit 1 means falling edge, 0 rising, per external pin
// - dma1, adc1, uart1 tx and rx requests land in bits 14 to 11
// - spi1 event, spi1 fault, timer3, timer2, compare2 land in bits 10 to 6
// - capture2, dma0, timer1 land in bits 5 to 3; bit 15 reads zero
// - sources set request flags, software clears them
// - priority field ignores software writes while nesting is disabled
package taic_pkg;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CORE = 8'h04;
  localparam logic [7:0] OFS_TRAP = 8'h08;
  localparam logic [7:0] OFS_VECTOR = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int STATUS_PRI_LSB = 5;
  localparam int CORE_PRI_UPPER = 3;
  localparam int TRAP_NEST_DIS = 15;
  localparam int TRAP_OVA = 14;
  localparam int TRAP_OVB = 13;
  localparam int TRAP_COVA = 12;
  localparam int TRAP_COVB = 11;
  localparam int TRAP_OVA_EN = 10;
  localparam int TRAP_OVB_EN = 9;
  localparam int TRAP_COV_EN = 8;
  localparam int TRAP_SHIFT = 7;
  localparam int TRAP_DIV0 = 6;
  localparam int TRAP_DMA = 5;
  localparam int TRAP_MATH = 4;
  localparam int TRAP_ADDR = 3;
  localparam int TRAP_STACK = 2;
  localparam int TRAP_OSC = 1;
  localparam int VEC_ALT = 15;
  localparam int VEC_TEMP_DISABLE_ACTIVE = 14;
  localparam int FLAG_EXT0 = 0;
  localparam int FLAG_SRC_LSB = 1;
  // -------------------------------------------------------------
  // masks and reset values
  // -------------------------------------------------------------
  localparam logic [15:0] TRAP_WMASK = 16'hfffe;
  localparam logic [15:0] VEC_WMASK = 16'h801f;
  localparam logic [15:0] FLAG_WMASK = 16'h7fff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0] PRI_LOW_MAX = 3'h7;
endpackage

// >>> logic/taic_top.sv
// trap and interrupt control registers with wishbone slave
// assumes sources give one-cycle pulses on the system clock; ext pins are async
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module taic_top #(
  parameter int EXT_PINS = 5
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic WB_ERR_OUT,
  // trap events from the core
  input wire logic ACC_A_OVF_IN,
  input wire logic ACC_B_OVF_IN,
  input wire logic ACC_A_CATA_IN,
  input wire logic ACC_B_CATA_IN,
  input wire logic BAD_SHIFT_IN,
  input wire logic DIV_ZERO_IN,
  input wire logic DMA_FAULT_IN,
  input wire logic ADDR_FAULT_IN,
  input wire logic STACK_FAULT_IN,
  input wire logic OSC_FAULT_IN,
  input wire logic TEMP_DISABLE_IN,
  // peripheral request pulses, bit 0 lands at flag bit 1
  input wire logic [13:0] PERIPH_REQ_IN,
  // external interrupt pins
  input wire logic [EXT_PINS-1:0] EXT_INT_IN,
  // to the core
  output logic [3:0] PRIORITY_LEVEL_OUT,
  output logic NESTING_DISABLE_OUT,
  output logic ALT_TABLE_SELECT_OUT,
  output logic ARITH_TRAP_OUT,
  output logic [15:0] REQUEST_FLAGS_OUT
);
  // -------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------
  if (EXT_PINS != 5) begin : g_bad_pins
    $error("only five external pins fit the flag layout");
  end

  logic [2:0] pri_low_reg;
  logic pri_upper_reg;
  logic [15:0] trap_reg;
  logic [15:0] trap_next;
  logic [15:0] vec_reg;
  logic [15:0] flag_reg;
  logic [15:0] flag_next;
  logic [EXT_PINS-1:0] sync1_reg;
  logic [EXT_PINS-1:0] sync2_reg;
  logic [EXT_PINS-1:0] sync3_reg;
  logic [EXT_PINS-1:0] level_reg;
  logic [EXT_PINS-1:0] ext_hit;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] wmask;
  logic [15:0] trap_set;
  logic [15:0] flag_set;
  logic ova_trap;
  logic ovb_trap;
  logic cova_trap;
  logic covb_trap;
  logic math_trap;

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] adr);
    mapped = hit(adr, taic_pkg::OFS_STATUS) | hit(adr, taic_pkg::OFS_CORE) | hit(adr, taic_pkg::OFS_TRAP) |
             hit(adr, taic_pkg::OFS_VECTOR) | hit(adr, taic_pkg::OFS_FLAGS);
  endfunction

  // new request only; ack drops the cycle after it is given
  assign req = WB_CYC_IN & WB_STB_IN & ~ack_reg & ~err_reg;
  // write lands on the edge at which the master samples ack high
  assign wr = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack_reg & mapped(WB_ADR_IN);
  assign wmask = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
  assign wdata = WB_DAT_IN[15:0];

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req & mapped(WB_ADR_IN);
      err_reg <= req & ~mapped(WB_ADR_IN);
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req & ~WB_WE_IN) begin
      rdata_reg <= 32'h0000_0000;
      if (hit(WB_ADR_IN, taic_pkg::OFS_STATUS)) begin
        rdata_reg[taic_pkg::STATUS_PRI_LSB +: 3] <= pri_low_reg;
      end else if (hit(WB_ADR_IN, taic_pkg::OFS_CORE)) begin
        rdata_reg[taic_pkg::CORE_PRI_UPPER] <= pri_upper_reg;
      end else if (hit(WB_ADR_IN, taic_pkg::OFS_TRAP)) begin
        rdata_reg[15:0] <= trap_reg;
      end else if (hit(WB_ADR_IN, taic_pkg::OFS_VECTOR)) begin
        rdata_reg[15:0] <= vec_reg;
      end else if (hit(WB_ADR_IN, taic_pkg::OFS_FLAGS)) begin
        rdata_reg[15:0] <= flag_reg;
      end
    end
  end

  assign WB_ACK_OUT = ack_reg;
  assign WB_ERR_OUT = err_reg;
  assign WB_DAT_OUT = rdata_reg;

  // -------------------------------------------------------------
  // priority level
  // -------------------------------------------------------------
  // upper bit cannot be set by software, only cleared, so traps cannot be masked
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pri_low_reg <= 3'h0;
    end else if (wr && hit(WB_ADR_IN, taic_pkg::OFS_STATUS) && WB_SEL_IN[0] &&
                 !trap_reg[taic_pkg::TRAP_NEST_DIS]) begin
      pri_low_reg <= wdata[taic_pkg::STATUS_PRI_LSB +: 3];
    end
  end

  // upper bit raised by any new hardware trap event, dropped by software clear-only write
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pri_upper_reg <= 1'b0;
    end else if (|trap_set[taic_pkg::TRAP_OVA:taic_pkg::TRAP_OSC]) begin
      pri_upper_reg <= 1'b1;
    end else if (wr && hit(WB_ADR_IN, taic_pkg::OFS_CORE) && WB_SEL_IN[0] &&
                 !wdata[taic_pkg::CORE_PRI_UPPER]) begin
      pri_upper_reg <= 1'b0;
    end
  end

  assign PRIORITY_LEVEL_OUT = {pri_upper_reg, pri_low_reg};
  assign NESTING_DISABLE_OUT = trap_reg[taic_pkg::TRAP_NEST_DIS];

  // -------------------------------------------------------------
  // trap status and control
  // -------------------------------------------------------------
  assign ova_trap = ACC_A_OVF_IN & trap_reg[taic_pkg::TRAP_OVA_EN];
  assign ovb_trap = ACC_B_OVF_IN & trap_reg[taic_pkg::TRAP_OVB_EN];
  assign cova_trap = ACC_A_CATA_IN & trap_reg[taic_pkg::TRAP_COV_EN];
  assign covb_trap = ACC_B_CATA_IN & trap_reg[taic_pkg::TRAP_COV_EN];
  assign math_trap = ova_trap | ovb_trap | cova_trap | covb_trap | BAD_SHIFT_IN | DIV_ZERO_IN;

  always_comb begin
    trap_set = 16'h0000;
    trap_set[taic_pkg::TRAP_OVA] = ova_trap;
    trap_set[taic_pkg::TRAP_OVB] = ovb_trap;
    trap_set[taic_pkg::TRAP_COVA] = cova_trap;
    trap_set[taic_pkg::TRAP_COVB] = covb_trap;
    trap_set[taic_pkg::TRAP_SHIFT] = BAD_SHIFT_IN;
    trap_set[taic_pkg::TRAP_DIV0] = DIV_ZERO_IN;
    trap_set[taic_pkg::TRAP_DMA] = DMA_FAULT_IN;
    trap_set[taic_pkg::TRAP_MATH] = math_trap;
    trap_set[taic_pkg::TRAP_ADDR] = ADDR_FAULT_IN;
    trap_set[taic_pkg::TRAP_STACK] = STACK_FAULT_IN;
    trap_set[taic_pkg::TRAP_OSC] = OSC_FAULT_IN;
  end

  always_comb begin
    trap_next = trap_reg;
    if (wr && hit(WB_ADR_IN, taic_pkg::OFS_TRAP)) begin
      trap_next = (trap_reg & ~(wmask & taic_pkg::TRAP_WMASK)) | (wdata & wmask & taic_pkg::TRAP_WMASK);
    end
    trap_next = trap_next | trap_set;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      trap_reg <= taic_pkg::REG_RESET;
    end else begin
      trap_reg <= trap_next;
    end
  end

  assign ARITH_TRAP_OUT = trap_reg[taic_pkg::TRAP_MATH];

  // -------------------------------------------------------------
  // vector table and edge polarity
  // -------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      vec_reg <= taic_pkg::REG_RESET;
    end else begin
      if (wr && hit(WB_ADR_IN, taic_pkg::OFS_VECTOR)) begin
        vec_reg <= (vec_reg & ~(wmask & taic_pkg::VEC_WMASK)) | (wdata & wmask & taic_pkg::VEC_WMASK);
      end
      vec_reg[taic_pkg::VEC_TEMP_DISABLE_ACTIVE] <= TEMP_DISABLE_IN;
    end
  end

  assign ALT_TABLE_SELECT_OUT = vec_reg[taic_pkg::VEC_ALT];

  // -------------------------------------------------------------
  // external pin edge detect
  // -------------------------------------------------------------
  // edge counts only when second and third stages agree on new level
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      level_reg <= '0;
    end else begin
      sync1_reg <= EXT_INT_IN;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // agreed level only moves when both late stages match
      level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));
    end
  end

  for (genvar i = 0; i < EXT_PINS; i++) begin : g_edge
    // rising when polarity 0, falling when polarity 1
    assign ext_hit[i] = (sync2_reg[i] == sync3_reg[i]) && (sync3_reg[i] != level_reg[i]) &&
                        (sync3_reg[i] != vec_reg[i]);
  end

  // -------------------------------------------------------------
  // first request flag register
  // -------------------------------------------------------------
  // only pin 0 owns a bit here; other pins set no request flag
  always_comb begin
    flag_set = 16'h0000;
    flag_set[taic_pkg::FLAG_EXT0] = ext_hit[0];
    flag_set[taic_pkg::FLAG_SRC_LSB +: 14] = PERIPH_REQ_IN;
  end

  always_comb begin
    flag_next = flag_reg;
    if (wr && hit(WB_ADR_IN, taic_pkg::OFS_FLAGS)) begin
      flag_next = (flag_reg & ~(wmask & taic_pkg::FLAG_WMASK)) | (wdata & wmask & taic_pkg::FLAG_WMASK);
    end
    flag_next = (flag_next | flag_set) & taic_pkg::FLAG_WMASK;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      flag_reg <= taic_pkg::REG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign REQUEST_FLAGS_OUT = flag_reg;
endmodule

// >>> sim/taic_properties.sv
// port checker for the trap and interrupt control block
// assumes it is bound onto taic_top, one clock domain
`timescale 1ns/1ns
module taic_properties (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // bus and events
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic WB_ACK_OUT,
  input wire logic ADDR_FAULT_IN,
  input wire logic DIV_ZERO_IN,
  input wire logic BAD_SHIFT_IN,
  input wire logic [13:0] PERIPH_REQ_IN,
  // core side
  input wire logic [3:0] PRIORITY_LEVEL_OUT,
  input wire logic NESTING_DISABLE_OUT,
  input wire logic ALT_TABLE_SELECT_OUT,
  input wire logic ARITH_TRAP_OUT,
  input wire logic [15:0] REQUEST_FLAGS_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  // word of the write acked now, 3f when none
  logic [5:0] wa;
  assign wa = (WB_ACK_OUT && WB_WE_IN) ? WB_ADR_IN[7:2] : 6'h3f;
  AST_UPPER_ON_TRAP: assert property (ADDR_FAULT_IN |=> PRIORITY_LEVEL_OUT[3])
    else $error("upper priority bit not set by trap");
  AST_MATH_ON_CAUSE: assert property (DIV_ZERO_IN || BAD_SHIFT_IN |=> ARITH_TRAP_OUT)
    else $error("math trap flag missing");
  AST_REQ_SETS_FLAG: assert property (PERIPH_REQ_IN != 14'h0 |=>
    (REQUEST_FLAGS_OUT[14:1] & $past(PERIPH_REQ_IN)) == $past(PERIPH_REQ_IN))
    else $error("request flag not set");
  AST_TOP_FLAG_ZERO: assert property (REQUEST_FLAGS_OUT[15] == 1'b0)
    else $error("flag bit 15 set");
  AST_FLAG_STICKY: assert property (|($past(REQUEST_FLAGS_OUT) & ~REQUEST_FLAGS_OUT) |->
    $past(wa) == taic_pkg::OFS_FLAGS[7:2]) else $error("flag cleared without write");
  AST_NEST_BY_WRITE: assert property ($changed(NESTING_DISABLE_OUT) |-> $past(wa) == taic_pkg::OFS_TRAP[7:2])
    else $error("nesting control changed without write");
  AST_PRI_FROZEN: assert property ($past(NESTING_DISABLE_OUT) |-> $stable(PRIORITY_LEVEL_OUT[2:0]))
    else $error("priority field moved while nesting disabled");
  AST_ALT_BY_WRITE: assert property ($changed(ALT_TABLE_SELECT_OUT) |-> $past(wa) == taic_pkg::OFS_VECTOR[7:2])
    else $error("table select changed without write");
endmodule
bind taic_top taic_properties chk_u (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .WB_WE_IN(WB_WE_IN),
  .WB_ADR_IN(WB_ADR_IN), .WB_ACK_OUT(WB_ACK_OUT), .ADDR_FAULT_IN(ADDR_FAULT_IN), .DIV_ZERO_IN(DIV_ZERO_IN),
  .BAD_SHIFT_IN(BAD_SHIFT_IN), .PERIPH_REQ_IN(PERIPH_REQ_IN), .PRIORITY_LEVEL_OUT(PRIORITY_LEVEL_OUT),
  .NESTING_DISABLE_OUT(NESTING_DISABLE_OUT), .ALT_TABLE_SELECT_OUT(ALT_TABLE_SELECT_OUT),
  .ARITH_TRAP_OUT(ARITH_TRAP_OUT), .REQUEST_FLAGS_OUT(REQUEST_FLAGS_OUT));

// >>> sim/taic_src_model.sv
// far-side model: core trap events and peripheral request pulses
// assumes the bench raises fire for one cycle per burst
`timescale 1ns/1ns
module taic_src_model (
  // clock and command
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [23:0] pattern_in,
  // events towards the block
  output logic [23:0] event_out
);
  // sources only pulse; holding the flag is the block's job
  always_ff @(posedge clk_in) begin
    event_out <= fire_in ? pattern_in : 24'h0;
  end
endmodule

// >>> sim/trap_and_interrupt_control_tb.sv
// self-checking bench for the trap and interrupt control block
// assumes the source model and the bound checker
`timescale 1ns/1ns
module trap_and_interrupt_control_tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, fire = 1'b0, temp = 1'b0, bus_err;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, dout;
  logic [23:0] pat = 24'h0, ev;
  logic [4:0] ext = 5'h0;
  logic ack, err, nest, alt, math;
  logic [3:0] lvl;
  logic [15:0] flg, rd, r;
  int errors = 0, checks = 0;
  always #25 clk = ~clk;
  taic_src_model src_u (.clk_in(clk), .fire_in(fire), .pattern_in(pat), .event_out(ev));
  taic_top dut_u (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(4'h3), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .WB_ERR_OUT(err),
    .ACC_A_OVF_IN(ev[23]), .ACC_B_OVF_IN(ev[22]), .ACC_A_CATA_IN(ev[21]), .ACC_B_CATA_IN(ev[20]),
    .BAD_SHIFT_IN(ev[19]), .DIV_ZERO_IN(ev[18]), .DMA_FAULT_IN(ev[17]), .ADDR_FAULT_IN(ev[16]),
    .STACK_FAULT_IN(ev[15]), .OSC_FAULT_IN(ev[14]), .TEMP_DISABLE_IN(temp), .PERIPH_REQ_IN(ev[13:0]),
    .EXT_INT_IN(ext), .PRIORITY_LEVEL_OUT(lvl), .NESTING_DISABLE_OUT(nest), .ALT_TABLE_SELECT_OUT(alt),
    .ARITH_TRAP_OUT(math), .REQUEST_FLAGS_OUT(flg));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // entered just after a rising edge; held until ack or err is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (!(ack || err) && n < 20);
    if (n >= 20) chk("bus answer", 16'h1, 16'h0);
    rd = dout[15:0];
    bus_err = err;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0);
    chk(name, exp, rd);
  endtask
  task automatic pulse(input logic [23:0] p);
    pat <= p;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [15:0] trap_exp(int i);
    int pos [10] = '{14, 13, 12, 11, 7, 6, 5, 3, 2, 1};
    return 16'h0700 | (16'h1 << pos[i]) | ((i < 6) ? 16'h0010 : 16'h0);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    chk("watchdog", 16'h0, 16'h1);
    summarize();
  end
  initial begin
    void'($urandom(93288));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rchk("reset value", 8'(4 * i), 16'h0);
    bus(1'b0, 8'h20, 16'h0);
    chk("unmapped err", 16'h1, {15'h0, bus_err});
    // vector table select and read-only temp disable bit
    bus(1'b1, taic_pkg::OFS_VECTOR, 16'hffff);
    chk("alt select", 16'h1, {15'h0, alt});
    temp <= 1'b1;
    repeat (2) @(posedge clk);
    rchk("vector reg", taic_pkg::OFS_VECTOR, 16'hc01f);
    temp <= 1'b0;
    bus(1'b1, taic_pkg::OFS_VECTOR, 16'h0);
    chk("alt select", 16'h0, {15'h0, alt});
    // priority field frozen while nesting disabled
    bus(1'b1, taic_pkg::OFS_STATUS, 16'h00e0);
    chk("priority level", 16'h7, {12'h0, lvl});
    bus(1'b1, taic_pkg::OFS_TRAP, 16'h8000);
    chk("nest disable", 16'h1, {15'h0, nest});
    bus(1'b1, taic_pkg::OFS_STATUS, 16'h0020);
    rchk("status frozen", taic_pkg::OFS_STATUS, 16'h00e0);
    bus(1'b1, taic_pkg::OFS_TRAP, 16'h0);
    bus(1'b1, taic_pkg::OFS_STATUS, 16'h0040);
    rchk("status open", taic_pkg::OFS_STATUS, 16'h0040);
    // disabled overflow and catastrophic events leave no trace
    pulse(24'hf00000);
    rchk("trap gated", taic_pkg::OFS_TRAP, 16'h0);
    rchk("core gated", taic_pkg::OFS_CORE, 16'h0);
    bus(1'b1, taic_pkg::OFS_TRAP, 16'h0700);
    for (int i = 0; i < 10; i++) begin
      pulse(24'h800000 >> i);
      rchk("trap status", taic_pkg::OFS_TRAP, trap_exp(i));
      chk("math out", {15'h0, i < 6}, {15'h0, math});
      rchk("core upper", taic_pkg::OFS_CORE, 16'h0008);
      chk("priority level", 16'ha, {12'h0, lvl});
      bus(1'b1, taic_pkg::OFS_TRAP, 16'h0700);
      bus(1'b1, taic_pkg::OFS_CORE, 16'h0);
      chk("priority level", 16'h2, {12'h0, lvl});
    end
    // random request bursts, all-ones first
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 16'h3fff : 16'($urandom) & 16'h3fff;
      pulse({10'h0, r[13:0]});
      rchk("flags set", taic_pkg::OFS_FLAGS, {1'b0, r[13:0], 1'b0});
      chk("flags out", {1'b0, r[13:0], 1'b0}, flg);
      bus(1'b1, taic_pkg::OFS_FLAGS, 16'hffff);
      rchk("flags written", taic_pkg::OFS_FLAGS, 16'h7fff);
      bus(1'b1, taic_pkg::OFS_FLAGS, 16'h0);
      rchk("flags cleared", taic_pkg::OFS_FLAGS, 16'h0);
    end
    // edge polarity on the external pins
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, taic_pkg::OFS_VECTOR, 16'(p));
      bus(1'b1, taic_pkg::OFS_FLAGS, 16'h0);
      ext <= 5'h1f;
      repeat (6) @(posedge clk);
      rchk("pin rise", taic_pkg::OFS_FLAGS, 16'(1 - p));
      bus(1'b1, taic_pkg::OFS_FLAGS, 16'h0);
      ext <= 5'h0;
      repeat (6) @(posedge clk);
      rchk("pin fall", taic_pkg::OFS_FLAGS, 16'(p));
    end
    summarize();
  end
endmodule
